//--- hdl/fepc_top.sv
// Flash and data EEPROM program controller with register bank and parallel writer port
// Overview of operation
// - Register bank reachable only in programming mode
// - Flash programming only via debug or parallel
// - Control bit 7 selects flash bulk erase
// - Control bit 6 selects EEPROM bulk erase
// - Exit only on code 11; self-clears
// - Write command starts program or erase; self-clears
// - Read command starts auto-verify; self-clears
// - Reset command resets control logic; self-clears
// - Commands use the indirect address registers
// - Cell access uses controller read/write strobes
// - Parallel address and data move bytewise
// - Address bytes arrive low byte first
// - Top address nibble selects target memory
// - Data access without address auto-increments
// - Parallel sequences match the serial ones
`timescale 1ns/1ns
`default_nettype none
module fepc_top (
	input wire logic CLK_SYS,
	input wire logic SRST,
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	output logic [7:0] SFR_RDATA,
	input wire logic DEBUG_ACTIVE,
	input wire logic PROG_ENTER,
	output logic PROG_MODE,
	input wire logic PAR_ENABLE,
	input wire logic PAR_ADDR_STB,
	input wire logic PAR_WR_STB,
	input wire logic PAR_RD_STB,
	input wire logic [7:0] PAR_DATA_IN,
	output logic [7:0] PAR_DATA_OUT,
	output logic PAR_DATA_OE_N,
	output logic [15:0] NVM_ADDR,
	output logic [7:0] NVM_WDATA,
	input wire logic [7:0] NVM_RDATA,
	output logic NVM_WE,
	output logic NVM_RE,
	output logic NVM_ERASE,
	output logic NVM_EEPROM_SEL,
	output logic NVM_BULK_FLASH,
	output logic NVM_BULK_EEPROM,
	output logic NVM_CTRL_RST,
	output logic [7:0] BUF_CHECKSUM
);
	import fepc_pkg::*;

	// Register offset decode, shared by the write and read paths
	function automatic logic bank_hit(input logic [7:0] a);
		bank_hit = (a == OFS_MODE) || (a == OFS_CTRL) || (a == OFS_STAT) ||
			(a == OFS_TIME) || (a == OFS_ADDR_LO) || (a == OFS_ADDR_MID) ||
			(a == OFS_ADDR_HI) || (a == OFS_DATA);
	endfunction : bank_hit

	// Pin synchroniser: three stages, value accepted when stages two and three agree
	logic [11:0] sy1_ff, sy2_ff, sy3_ff; // Synchroniser stages
	logic [11:0] filt_ff, nxt_filt; // Accepted pin levels
	logic [11:0] filt_d_ff; // Accepted levels one cycle late, for edges
	always_comb begin
		nxt_filt = filt_ff;
		for (int i = 0; i < 12; i++) begin
			if (sy2_ff[i] == sy3_ff[i]) begin
				nxt_filt[i] = sy3_ff[i];
			end
		end
	end
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			sy1_ff <= 12'h000;
			sy2_ff <= 12'h000;
			sy3_ff <= 12'h000;
			filt_ff <= 12'h000;
			filt_d_ff <= 12'h000;
		end else begin
			sy1_ff <= {PAR_ENABLE, PAR_ADDR_STB, PAR_WR_STB, PAR_RD_STB, PAR_DATA_IN};
			sy2_ff <= sy1_ff;
			sy3_ff <= sy2_ff;
			filt_ff <= nxt_filt;
			filt_d_ff <= filt_ff;
		end
	end

	logic par_mode; // Writer holds the parallel mode pin
	logic [7:0] par_byte; // Byte presented by the writer
	logic astb_rise, wstb_rise, rstb_rise; // One-cycle strobe events
	assign par_mode = filt_ff[SY_EN];
	assign par_byte = filt_ff[7:0];
	assign astb_rise = par_mode && filt_ff[SY_ASTB] && !filt_d_ff[SY_ASTB];
	assign wstb_rise = par_mode && filt_ff[SY_WSTB] && !filt_d_ff[SY_WSTB];
	assign rstb_rise = par_mode && filt_ff[SY_RSTB] && !filt_d_ff[SY_RSTB];

	// Register state
	logic [7:0] mode_ff, nxt_mode; // Operation mode
	logic [7:0] ctrl_ff, nxt_ctrl; // Bulk selects and self-clearing commands
	logic [2:0] stat_ff, nxt_stat; // Sticky done, verify error, refused
	logic [7:0] time_ff, nxt_time; // Wait per cell operation
	logic [23:0] addr_ff, nxt_addr; // Indirect address set
	logic [7:0] data_ff, nxt_data; // Data register
	logic [1:0] aidx_ff, nxt_aidx; // Next parallel address byte
	logic prog_ff, nxt_prog; // Programming mode
	logic priv_ff, nxt_priv; // Last command came from a privileged path
	logic [7:0] csum_ff, nxt_csum; // Running sum of buffer loads
	logic [7:0] rdata_ff, nxt_rdata; // Bus read data
	logic [7:0] pdout_ff, nxt_pdout; // Parallel read data
	logic poe_n_ff, nxt_poe_n; // Parallel drive enable, low drives

	// Sequencer state
	fepc_state_type state_ff, nxt_state;
	logic [4:0] idx_ff, nxt_idx; // Byte within the page
	logic [7:0] wait_ff, nxt_wait; // Cell wait countdown
	logic erase_ff, nxt_erase; // Current operation erases
	logic [15:0] naddr_ff, nxt_naddr;
	logic [7:0] nwdata_ff, nxt_nwdata;
	logic nwe_ff, nxt_nwe, nre_ff, nxt_nre, nrst_ff, nxt_nrst;
	logic set_done, set_verr, set_refused; // Status events from the sequencer

	// Unified register access from the bus or the parallel SFR target
	logic [3:0] tgt;
	logic par_sfr;
	logic acc_wr, acc_rd, acc_priv;
	logic [7:0] acc_addr, acc_wdata, rd_val;
	logic buf_we, buf_clear;
	logic [4:0] buf_waddr;
	logic [7:0] buf_rdata;
	assign tgt = addr_ff[23:20];
	assign par_sfr = (tgt == TGT_SFR);
	assign acc_addr = par_mode ? addr_ff[7:0] : SFR_ADDR;
	assign acc_wdata = par_mode ? par_byte : SFR_WDATA;
	assign acc_priv = par_mode || DEBUG_ACTIVE;
	assign acc_wr = prog_ff && bank_hit(acc_addr) &&
		(par_mode ? (wstb_rise && par_sfr) : SFR_WR);
	assign acc_rd = prog_ff && bank_hit(acc_addr) &&
		(par_mode ? (rstb_rise && par_sfr) : SFR_RD);

	// Read mux; command bits show their one live cycle then zero
	always_comb begin
		rd_val = 8'h00;
		unique case (acc_addr)
			OFS_MODE: rd_val = mode_ff;
			OFS_CTRL: rd_val = ctrl_ff;
			OFS_STAT: rd_val = {(state_ff == S_IDLE), 4'h0, stat_ff};
			OFS_TIME: rd_val = time_ff;
			OFS_ADDR_LO: rd_val = addr_ff[7:0];
			OFS_ADDR_MID: rd_val = addr_ff[15:8];
			OFS_ADDR_HI: rd_val = addr_ff[23:16];
			OFS_DATA: rd_val = data_ff;
			default: rd_val = 8'h00;
		endcase
	end

	// Register next values
	always_comb begin
		nxt_mode = mode_ff;
		nxt_ctrl = ctrl_ff & ~CTRL_CMD_MASK;
		nxt_stat = stat_ff;
		nxt_time = time_ff;
		nxt_addr = addr_ff;
		nxt_data = data_ff;
		nxt_aidx = aidx_ff;
		nxt_prog = prog_ff;
		nxt_priv = priv_ff;
		nxt_csum = csum_ff;
		nxt_rdata = 8'h00;
		nxt_pdout = pdout_ff;
		nxt_poe_n = !(par_mode && filt_ff[SY_RSTB]);
		buf_we = 1'b0;
		buf_waddr = addr_ff[4:0];
		buf_clear = 1'b0;
		// Entry into programming mode
		if (PROG_ENTER) begin
			nxt_prog = 1'b1;
		end
		if (wstb_rise && tgt == TGT_PROG && addr_ff[15:0] == ENTRY_ADDR &&
			par_byte == ENTRY_DATA) begin
			nxt_prog = 1'b1;
		end
		// Exit only on the all-ones code
		if (ctrl_ff[CTRL_EXIT_HI_BIT] && ctrl_ff[CTRL_EXIT_LO_BIT]) begin
			nxt_prog = 1'b0;
		end
		// Parallel address bytes, low byte first
		if (astb_rise) begin
			unique case (aidx_ff)
				2'd0: nxt_addr[7:0] = par_byte;
				2'd1: nxt_addr[15:8] = par_byte;
				default: nxt_addr[23:16] = par_byte;
			endcase
			nxt_aidx = (aidx_ff == 2'd2) ? 2'd0 : aidx_ff + 2'd1;
		end
		// Data access without a new address moves on to the next location
		if (wstb_rise || rstb_rise) begin
			nxt_aidx = 2'd0;
			nxt_addr = addr_ff + 24'h000001;
		end
		// Parallel write to program memory loads the page buffer
		if (wstb_rise && prog_ff && tgt == TGT_PROG) begin
			buf_we = 1'b1;
			nxt_data = par_byte;
		end
		if (rstb_rise && tgt == TGT_EXT) begin
			nxt_pdout = ERASED_BYTE; // External memory is not reachable here
		end
		if (acc_rd) begin
			if (par_mode) begin
				nxt_pdout = rd_val;
			end else begin
				nxt_rdata = rd_val;
			end
		end
		if (state_ff == S_PRD_CAP) begin
			nxt_pdout = NVM_RDATA;
		end
		// Register writes
		if (acc_wr) begin
			unique case (acc_addr)
				OFS_MODE: nxt_mode = acc_wdata;
				OFS_CTRL: begin
					nxt_ctrl = acc_wdata;
					nxt_priv = acc_priv;
				end
				OFS_STAT: nxt_stat = stat_ff & ~acc_wdata[2:0];
				OFS_TIME: nxt_time = acc_wdata;
				OFS_ADDR_LO: nxt_addr[7:0] = acc_wdata;
				OFS_ADDR_MID: nxt_addr[15:8] = acc_wdata;
				OFS_ADDR_HI: nxt_addr[23:16] = acc_wdata;
				OFS_DATA: begin
					nxt_data = acc_wdata;
					buf_we = 1'b1;
				end
				default: nxt_mode = mode_ff;
			endcase
		end
		if (buf_we) begin
			nxt_csum = csum_ff + nxt_data;
		end
		// Status events win over a clear in the same cycle
		if (set_done) begin
			nxt_stat[STAT_DONE_BIT] = 1'b1;
		end
		if (set_verr) begin
			nxt_stat[STAT_VERR_BIT] = 1'b1;
		end
		if (set_refused) begin
			nxt_stat[STAT_REFUSED_BIT] = 1'b1;
		end
		// Controller reset drops status; page buffer reset picks buffer or sum
		if (ctrl_ff[CTRL_FERST_BIT]) begin
			nxt_stat = 3'b000;
		end
		if (ctrl_ff[CTRL_PBRST_BIT]) begin
			if (mode_ff[MODE_BUFFER_CHECKSUM_SELECT_BIT]) begin
				nxt_csum = 8'h00;
			end else begin
				buf_clear = 1'b1;
			end
		end
	end

	// Register flip-flops
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			mode_ff <= RST_MODE;
			ctrl_ff <= RST_CTRL;
			stat_ff <= RST_STAT[2:0];
			time_ff <= RST_TIME;
			addr_ff <= RST_ADDR;
			data_ff <= RST_DATA;
			aidx_ff <= 2'd0;
			prog_ff <= 1'b0;
			priv_ff <= 1'b0;
			csum_ff <= 8'h00;
			rdata_ff <= 8'h00;
			pdout_ff <= 8'h00;
			poe_n_ff <= 1'b1;
		end else begin
			mode_ff <= nxt_mode;
			ctrl_ff <= nxt_ctrl;
			stat_ff <= nxt_stat;
			time_ff <= nxt_time;
			addr_ff <= nxt_addr;
			data_ff <= nxt_data;
			aidx_ff <= nxt_aidx;
			prog_ff <= nxt_prog;
			priv_ff <= nxt_priv;
			csum_ff <= nxt_csum;
			rdata_ff <= nxt_rdata;
			pdout_ff <= nxt_pdout;
			poe_n_ff <= nxt_poe_n;
		end
	end

	// Page buffer
	fepc_page_buf i_fepc_page_buf (
		.clk(CLK_SYS),
		.srst(SRST),
		.clear(buf_clear),
		.we(buf_we),
		.waddr(buf_waddr),
		.wdata(nxt_data),
		.raddr(idx_ff),
		.rdata(buf_rdata)
	);

	// Sequencer next values: page program, erase, verify and parallel read
	always_comb begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		nxt_wait = wait_ff;
		nxt_erase = erase_ff;
		nxt_naddr = naddr_ff;
		nxt_nwdata = nwdata_ff;
		nxt_nwe = 1'b0;
		nxt_nre = 1'b0;
		nxt_nrst = 1'b0;
		set_done = 1'b0;
		set_verr = 1'b0;
		set_refused = 1'b0;
		unique case (state_ff)
			S_IDLE: begin
				nxt_idx = 5'h00;
				if (ctrl_ff[CTRL_WRITE_BIT]) begin
					// Flash needs a privileged path; EEPROM is open to code
					if (mode_ff[MODE_EEP_BIT] || priv_ff) begin
						nxt_erase = mode_ff[MODE_ERASE_BIT];
						if (mode_ff[MODE_ERASE_BIT]) begin
							nxt_naddr = addr_ff[15:0];
							nxt_nwe = 1'b1;
							nxt_wait = time_ff;
							nxt_state = S_WAIT;
						end else begin
							nxt_state = S_PGM_RD;
						end
					end else begin
						set_refused = 1'b1;
					end
				end else if (ctrl_ff[CTRL_READ_BIT]) begin
					nxt_naddr = {addr_ff[15:5], 5'h00};
					nxt_nre = 1'b1;
					nxt_state = S_VFY_HOLD;
				end else if (rstb_rise && tgt == TGT_PROG) begin
					nxt_naddr = addr_ff[15:0];
					nxt_nre = 1'b1;
					nxt_state = S_PRD;
				end
			end
			S_PGM_RD: nxt_state = S_PGM_WE;
			S_PGM_WE: begin
				nxt_naddr = {addr_ff[15:5], idx_ff};
				nxt_nwdata = buf_rdata;
				nxt_nwe = 1'b1;
				nxt_wait = time_ff;
				nxt_state = S_WAIT;
			end
			S_WAIT: begin
				if (wait_ff != 8'h00) begin
					nxt_wait = wait_ff - 8'h01;
				end else if (erase_ff || idx_ff == PAGE_LAST) begin
					set_done = 1'b1;
					nxt_erase = 1'b0;
					nxt_state = S_IDLE;
				end else begin
					nxt_idx = idx_ff + 5'h01;
					nxt_state = S_PGM_RD;
				end
			end
			S_VFY_HOLD: nxt_state = S_VFY_CMP;
			S_VFY_CMP: begin
				if (NVM_RDATA != buf_rdata) begin
					set_verr = 1'b1;
				end
				if (idx_ff == PAGE_LAST) begin
					set_done = 1'b1;
					nxt_state = S_IDLE;
				end else begin
					nxt_idx = idx_ff + 5'h01;
					nxt_naddr = {addr_ff[15:5], idx_ff + 5'h01};
					nxt_nre = 1'b1;
					nxt_state = S_VFY_HOLD;
				end
			end
			S_PRD: nxt_state = S_PRD_CAP;
			S_PRD_CAP: nxt_state = S_IDLE;
		endcase
		// Controller reset abandons any operation at once
		if (ctrl_ff[CTRL_FERST_BIT]) begin
			nxt_state = S_IDLE;
			nxt_erase = 1'b0;
			nxt_nwe = 1'b0;
			nxt_nre = 1'b0;
			nxt_nrst = 1'b1;
			set_done = 1'b0;
			set_verr = 1'b0;
			set_refused = 1'b0;
		end
	end

	// Sequencer flip-flops
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			state_ff <= S_IDLE;
			idx_ff <= 5'h00;
			wait_ff <= 8'h00;
			erase_ff <= 1'b0;
			naddr_ff <= 16'h0000;
			nwdata_ff <= 8'h00;
			nwe_ff <= 1'b0;
			nre_ff <= 1'b0;
			nrst_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			wait_ff <= nxt_wait;
			erase_ff <= nxt_erase;
			naddr_ff <= nxt_naddr;
			nwdata_ff <= nxt_nwdata;
			nwe_ff <= nxt_nwe;
			nre_ff <= nxt_nre;
			nrst_ff <= nxt_nrst;
		end
	end

	// Outputs, each straight from a flip-flop
	assign SFR_RDATA = rdata_ff;
	assign PROG_MODE = prog_ff;
	assign PAR_DATA_OUT = pdout_ff;
	assign PAR_DATA_OE_N = poe_n_ff;
	assign NVM_ADDR = naddr_ff;
	assign NVM_WDATA = nwdata_ff;
	assign NVM_WE = nwe_ff;
	assign NVM_RE = nre_ff;
	assign NVM_ERASE = erase_ff;
	assign NVM_EEPROM_SEL = mode_ff[MODE_EEP_BIT];
	assign NVM_BULK_FLASH = ctrl_ff[CTRL_BULK_FLASH_BIT];
	assign NVM_BULK_EEPROM = ctrl_ff[CTRL_BULK_EEP_BIT];
	assign NVM_CTRL_RST = nrst_ff;
	assign BUF_CHECKSUM = csum_ff;
endmodule : fepc_top
`default_nettype wire

//--- hdl/fepc_pkg.sv
// Constants, register map and state type of the flash and EEPROM program controller
package fepc_pkg;
	// Register offsets in the special-function area
	localparam logic [7:0] OFS_MODE = 8'hEA;
	localparam logic [7:0] OFS_CTRL = 8'hEB;
	localparam logic [7:0] OFS_STAT = 8'hEC;
	localparam logic [7:0] OFS_TIME = 8'hED;
	localparam logic [7:0] OFS_ADDR_LO = 8'hF2;
	localparam logic [7:0] OFS_ADDR_MID = 8'hF3;
	localparam logic [7:0] OFS_ADDR_HI = 8'hF4;
	localparam logic [7:0] OFS_DATA = 8'hF5;
	// Reset values
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h03;
	localparam logic [7:0] RST_STAT = 8'h80;
	localparam logic [7:0] RST_TIME = 8'h00;
	localparam logic [23:0] RST_ADDR = 24'h000000;
	localparam logic [7:0] RST_DATA = 8'h00;
	// Control register fields
	localparam int CTRL_BULK_FLASH_BIT = 7;
	localparam int CTRL_BULK_EEP_BIT = 6;
	localparam int CTRL_EXIT_HI_BIT = 5;
	localparam int CTRL_EXIT_LO_BIT = 4;
	localparam int CTRL_WRITE_BIT = 3;
	localparam int CTRL_READ_BIT = 2;
	localparam int CTRL_FERST_BIT = 1;
	localparam int CTRL_PBRST_BIT = 0;
	localparam logic [7:0] CTRL_CMD_MASK = 8'h3F;
	// Mode register fields
	localparam int MODE_EEP_BIT = 0;
	localparam int MODE_ERASE_BIT = 1;
	localparam int MODE_BUFFER_CHECKSUM_SELECT_BIT = 7;
	// Status register fields
	localparam int STAT_READY_BIT = 7;
	localparam int STAT_REFUSED_BIT = 2;
	localparam int STAT_VERR_BIT = 1;
	localparam int STAT_DONE_BIT = 0;
	localparam logic [7:0] STAT_W1C_MASK = 8'h07;
	// Parallel target codes in the top nibble of the high address byte
	localparam logic [3:0] TGT_PROG = 4'h0;
	localparam logic [3:0] TGT_EXT = 4'h1;
	localparam logic [3:0] TGT_SFR = 4'h2;
	// Entry sequence first write
	localparam logic [15:0] ENTRY_ADDR = 16'hF555;
	localparam logic [7:0] ENTRY_DATA = 8'hAA;
	// Page buffer geometry and erased value
	localparam int PAGE_AW = 5;
	localparam logic [4:0] PAGE_LAST = 5'h1F;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// Bit positions of the synchronised parallel pins
	localparam int SY_EN = 11;
	localparam int SY_ASTB = 10;
	localparam int SY_WSTB = 9;
	localparam int SY_RSTB = 8;
	// Sequencer states
	typedef enum logic [3:0] {
		S_IDLE,
		S_PGM_RD,
		S_PGM_WE,
		S_WAIT,
		S_VFY_HOLD,
		S_VFY_CMP,
		S_PRD,
		S_PRD_CAP
	} fepc_state_type;
endpackage : fepc_pkg

//--- hdl/fepc_page_buf.sv
// Page buffer memory with registered read data and one-cycle clear
`timescale 1ns/1ns
`default_nettype none
module fepc_page_buf (
	input wire logic clk,
	input wire logic srst,
	input wire logic clear,
	input wire logic we,
	input wire logic [fepc_pkg::PAGE_AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [fepc_pkg::PAGE_AW-1:0] raddr,
	output logic [7:0] rdata
);
	import fepc_pkg::*;
	logic [7:0] mem_ff [0:(1<<PAGE_AW)-1]; // Byte storage
	logic [(1<<PAGE_AW)-1:0] valid_ff; // Loaded flags; unloaded bytes read erased
	logic [7:0] rdata_ff; // Registered read port

	// Storage and flags; clearing only drops flags so it costs one cycle
	always_ff @(posedge clk) begin
		if (srst || clear) begin
			valid_ff <= '0;
		end else if (we) begin
			valid_ff[waddr] <= 1'b1;
		end
		if (we) begin
			mem_ff[waddr] <= wdata;
		end
		if (srst) begin
			rdata_ff <= ERASED_BYTE;
		end else begin
			rdata_ff <= valid_ff[raddr] ? mem_ff[raddr] : ERASED_BYTE;
		end
	end

	assign rdata = rdata_ff;
endmodule : fepc_page_buf
`default_nettype wire

//--- testbench/fepc_chk.sv
// Port-level assertion checker for the program controller
`timescale 1ns/1ns
`default_nettype none
module fepc_chk
	import fepc_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic SRST,
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_RDATA,
	input wire logic PAR_ENABLE,
	input wire logic PROG_MODE,
	input wire logic NVM_WE,
	input wire logic NVM_RE,
	input wire logic NVM_BULK_FLASH,
	input wire logic NVM_BULK_EEPROM,
	input wire logic NVM_CTRL_RST
);
	// Control write that the bank accepts; parallel mode must be long idle
	wire logic wr_ctrl = PROG_MODE && SFR_WR && !PAR_ENABLE && SFR_ADDR == OFS_CTRL;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	a_gate_read: assert property (!PROG_MODE && SFR_RD |=> SFR_RDATA == 8'h00)
		else $error("register read outside programming mode not zero");
	a_exit_code: assert property (wr_ctrl && SFR_WDATA[5:4] == 2'b11 |=> ##[0:2] !PROG_MODE)
		else $error("exit code 11 did not leave programming mode");
	// Bench spaces its writes two cycles apart, so two cycles of hold are safe
	a_exit_hold: assert property (wr_ctrl && SFR_WDATA[5:4] != 2'b11 |=> PROG_MODE [*2])
		else $error("exit code other than 11 left programming mode");
	a_bulk_flash: assert property ((wr_ctrl && !SFR_WDATA[1]) ##1 !wr_ctrl
		|=> NVM_BULK_FLASH == $past(SFR_WDATA[7], 2)) else $error("flash bulk select wrong");
	a_bulk_eeprom: assert property ((wr_ctrl && !SFR_WDATA[1]) ##1 !wr_ctrl
		|=> NVM_BULK_EEPROM == $past(SFR_WDATA[6], 2)) else $error("eeprom bulk select wrong");
	a_ctrl_reset: assert property (wr_ctrl && SFR_WDATA[1] |=> ##[0:2] NVM_CTRL_RST)
		else $error("controller reset command gave no reset pulse");
	a_reset_pulse: assert property (NVM_CTRL_RST |=> !NVM_CTRL_RST)
		else $error("controller reset longer than one cycle");
	a_we_pulse: assert property (NVM_WE |=> !NVM_WE)
		else $error("memory write strobe longer than one cycle");
	a_verify_start: assert property (wr_ctrl && SFR_WDATA[2] && !SFR_WDATA[3]
		&& !SFR_WDATA[1] |=> ##[1:6] NVM_RE) else $error("verify command gave no read strobe");
	c_exit: cover property (wr_ctrl && SFR_WDATA[5:4] == 2'b11);
	c_verify: cover property (NVM_RE);
	c_reset: cover property (NVM_CTRL_RST);
endmodule : fepc_chk
bind fepc_top fepc_chk i_fepc_chk (.CLK_SYS(CLK_SYS), .SRST(SRST), .SFR_ADDR(SFR_ADDR),
	.SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
	.PAR_ENABLE(PAR_ENABLE), .PROG_MODE(PROG_MODE), .NVM_WE(NVM_WE), .NVM_RE(NVM_RE),
	.NVM_BULK_FLASH(NVM_BULK_FLASH), .NVM_BULK_EEPROM(NVM_BULK_EEPROM),
	.NVM_CTRL_RST(NVM_CTRL_RST));
`default_nettype wire

//--- testbench/fepc_writer_model.sv
// Byte-parallel writer model driving the programming pins
`timescale 1ns/1ns
`default_nettype none
module fepc_writer_model (
	input wire logic clk,
	output logic en,
	output logic astb,
	output logic wstb,
	output logic [7:0] dout
);
	// Pins idle low until a frame starts
	initial begin
		en = 1'b0;
		astb = 1'b0;
		wstb = 1'b0;
		dout = 8'h00;
	end
	// One byte; strobe held six clocks to clear the input filter
	task automatic put_byte(input logic is_addr, input logic [7:0] b);
		dout <= b;
		repeat (2) @(posedge clk);
		astb <= is_addr;
		wstb <= !is_addr;
		repeat (6) @(posedge clk);
		astb <= 1'b0;
		wstb <= 1'b0;
		repeat (2) @(posedge clk);
		dout <= ~b; // Released bus must not show the last byte
		repeat (4) @(posedge clk);
	endtask : put_byte
	// Entry: three address bytes low first, then data 0xAA
	task automatic enter_prog();
		en <= 1'b1;
		repeat (8) @(posedge clk);
		for (int i = 0; i < 3; i++) begin
			put_byte(1'b1, 8'({24'h00F555} >> (8 * i)));
		end
		put_byte(1'b0, 8'hAA);
	endtask : enter_prog
	// Drop the mode pin and let the input filter settle
	task automatic leave_par();
		en <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : leave_par
endmodule : fepc_writer_model
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the flash and EEPROM program controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import fepc_pkg::*;
	logic CLK_SYS, SRST, SFR_WR, SFR_RD, DEBUG_ACTIVE, PROG_ENTER, PAR_RD_STB;
	logic [7:0] SFR_ADDR, SFR_WDATA, NVM_RDATA, flip;
	wire logic [7:0] SFR_RDATA, PAR_DATA_OUT, PAR_DATA_IN, NVM_WDATA, BUF_CHECKSUM;
	wire logic [15:0] NVM_ADDR;
	wire logic PROG_MODE, PAR_DATA_OE_N, NVM_WE, NVM_RE, NVM_ERASE, NVM_EEPROM_SEL;
	wire logic NVM_BULK_FLASH, NVM_BULK_EEPROM, NVM_CTRL_RST, PAR_ENABLE, PAR_ADDR_STB, PAR_WR_STB;
	int fails, tests_run;
	int we_total = 0; // Cell write strobes seen, counted only by the cell model
	logic [7:0] mem [0:65535]; // Cell array behind the strobes
	fepc_top i_fepc_top (.CLK_SYS(CLK_SYS), .SRST(SRST), .SFR_ADDR(SFR_ADDR),
		.SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
		.DEBUG_ACTIVE(DEBUG_ACTIVE), .PROG_ENTER(PROG_ENTER), .PROG_MODE(PROG_MODE),
		.PAR_ENABLE(PAR_ENABLE), .PAR_ADDR_STB(PAR_ADDR_STB), .PAR_WR_STB(PAR_WR_STB),
		.PAR_RD_STB(PAR_RD_STB), .PAR_DATA_IN(PAR_DATA_IN), .PAR_DATA_OUT(PAR_DATA_OUT),
		.PAR_DATA_OE_N(PAR_DATA_OE_N), .NVM_ADDR(NVM_ADDR), .NVM_WDATA(NVM_WDATA),
		.NVM_RDATA(NVM_RDATA), .NVM_WE(NVM_WE), .NVM_RE(NVM_RE), .NVM_ERASE(NVM_ERASE),
		.NVM_EEPROM_SEL(NVM_EEPROM_SEL), .NVM_BULK_FLASH(NVM_BULK_FLASH),
		.NVM_BULK_EEPROM(NVM_BULK_EEPROM), .NVM_CTRL_RST(NVM_CTRL_RST),
		.BUF_CHECKSUM(BUF_CHECKSUM));
	fepc_writer_model i_fepc_writer_model (.clk(CLK_SYS), .en(PAR_ENABLE), .astb(PAR_ADDR_STB),
		.wstb(PAR_WR_STB), .dout(PAR_DATA_IN));
	// 50 MHz system clock
	initial begin
		CLK_SYS = 1'b0;
		forever #10 CLK_SYS = ~CLK_SYS;
	end
	// Cells: write on strobe, erase on strobe with erase high; flip corrupts reads
	always @(posedge CLK_SYS) begin
		if (NVM_WE) begin
			mem[NVM_ADDR] <= NVM_ERASE ? ERASED_BYTE : NVM_WDATA;
			we_total <= we_total + 1;
		end
		NVM_RDATA <= mem[NVM_ADDR] ^ flip;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Register write: one-cycle strobe, then an idle cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		SFR_ADDR <= a;
		SFR_WDATA <= d;
		SFR_WR <= 1'b1;
		@(posedge CLK_SYS);
		SFR_WR <= 1'b0;
		@(posedge CLK_SYS);
	endtask : wr
	// Register read: data stands in the cycle right after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		SFR_ADDR <= a;
		SFR_RD <= 1'b1;
		@(posedge CLK_SYS);
		SFR_RD <= 1'b0;
		#1 d = SFR_RDATA;
		@(posedge CLK_SYS);
	endtask : rd
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(v, e);
	endtask : rd_chk
	task automatic final_report();
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report
	// Poll status for done; a bound that runs out ends the run
	task automatic wait_done(output logic [7:0] s);
		for (int i = 0; i < 200; i++) begin
			rd(OFS_STAT, s);
			if (s[STAT_DONE_BIT] === 1'b1) return;
		end
		fails++;
		$display("MISMATCH t=%0t operation never finished", $time);
		final_report();
	endtask : wait_done
	// Bank is hidden before programming mode; writes are dropped
	task automatic t_gate();
		wr(OFS_TIME, 8'h5A);
		rd_chk(OFS_TIME, 8'h00);
		rd_chk(OFS_STAT, 8'h00);
	endtask : t_gate
	// Reset values of the bank and an unmapped offset
	task automatic t_regs();
		rd_chk(OFS_MODE, RST_MODE);
		rd_chk(OFS_CTRL, 8'h00);
		rd_chk(OFS_STAT, RST_STAT);
		rd_chk(OFS_TIME, RST_TIME);
		rd_chk(OFS_ADDR_LO, RST_ADDR[7:0]);
		rd_chk(OFS_ADDR_MID, RST_ADDR[15:8]);
		rd_chk(OFS_ADDR_HI, RST_ADDR[23:16]);
		rd_chk(OFS_DATA, RST_DATA);
		rd_chk(8'hEE, 8'h00);
	endtask : t_regs
	// All four codes of the two bulk-erase selects, ending at 00
	task automatic t_bulk();
		logic [7:0] c;
		for (int i = 0; i < 4; i++) begin
			c = {2'(i + 1), 6'h00};
			wr(OFS_CTRL, c);
			#1 chk({6'h00, NVM_BULK_FLASH, NVM_BULK_EEPROM}, {6'h00, c[7:6]});
		end
	endtask : t_bulk
	// Flash page program through the indirect address at 0x001240
	task automatic t_program();
		logic [7:0] s;
		int w0;
		wr(OFS_TIME, 8'h02);
		rd_chk(OFS_TIME, 8'h02);
		wr(OFS_MODE, 8'h00);
		wr(OFS_ADDR_LO, 8'h40);
		wr(OFS_ADDR_MID, 8'h12);
		wr(OFS_ADDR_HI, 8'h00);
		wr(OFS_DATA, 8'h5A);
		w0 = we_total;
		wr(OFS_CTRL, 8'h08);
		rd_chk(OFS_CTRL, 8'h00);
		wait_done(s);
		chk(s & 8'h07, 8'h01);
		chk(8'(we_total - w0), 8'h20);
		chk(mem[16'h1240], 8'h5A);
	endtask : t_program
	// Auto-verify passes, then flags a corrupted read
	task automatic t_verify();
		logic [7:0] s;
		for (int i = 0; i < 2; i++) begin
			flip <= 8'(i);
			wr(OFS_STAT, STAT_W1C_MASK);
			wr(OFS_CTRL, 8'h04);
			wait_done(s);
			chk({7'h00, s[STAT_VERR_BIT]}, 8'(i));
		end
		flip <= 8'h00;
	endtask : t_verify
	// Flash program from the plain path is refused and starts nothing
	task automatic t_refuse();
		logic [7:0] s;
		int w0;
		DEBUG_ACTIVE <= 1'b0;
		wr(OFS_STAT, STAT_W1C_MASK);
		w0 = we_total;
		wr(OFS_CTRL, 8'h08);
		repeat (20) @(posedge CLK_SYS);
		rd(OFS_STAT, s);
		chk(s & 8'h05, 8'h04);
		chk(8'(we_total - w0), 8'h00);
		// EEPROM erase stays open to the plain path
		wr(OFS_MODE, 8'h03);
		wr(OFS_CTRL, 8'h08);
		wait_done(s);
		chk(s & 8'h07, 8'h05);
		chk({7'h00, NVM_EEPROM_SEL}, 8'h01);
		chk(mem[16'h1240], ERASED_BYTE);
		DEBUG_ACTIVE <= 1'b1;
	endtask : t_refuse
	// Controller reset: exactly one reset pulse, refused flag cleared
	task automatic t_crst();
		int n;
		n = 0;
		wr(OFS_CTRL, 8'h02);
		// The pulse stands in the cycle right after wr returns
		repeat (4) begin
			#1 if (NVM_CTRL_RST === 1'b1) n++;
			@(posedge CLK_SYS);
		end
		chk(8'(n), 8'h01);
		rd_chk(OFS_STAT, RST_STAT);
	endtask : t_crst
	// Exit codes 01 and 10 keep the mode, 11 leaves it
	task automatic t_exit();
		for (int i = 1; i < 4; i++) begin
			wr(OFS_CTRL, {2'b00, 2'(i), 4'h0});
			repeat (2) @(posedge CLK_SYS);
			#1 chk({7'h00, PROG_MODE}, {7'h00, i != 3});
		end
		rd_chk(OFS_MODE, 8'h00);
	endtask : t_exit
	// Parallel entry, auto-increment, external target and a pin read
	task automatic t_par();
		i_fepc_writer_model.enter_prog();
		for (int i = 0; i < 50 && PROG_MODE !== 1'b1; i++) @(posedge CLK_SYS);
		chk({7'h00, PROG_MODE}, 8'h01);
		i_fepc_writer_model.put_byte(1'b0, 8'h11);
		for (int i = 0; i < 3; i++) begin
			i_fepc_writer_model.put_byte(1'b1, (i == 2) ? 8'h10 : 8'h00);
		end
		i_fepc_writer_model.put_byte(1'b0, 8'h22);
		PAR_RD_STB <= 1'b1;
		repeat (6) @(posedge CLK_SYS);
		#1 chk(PAR_DATA_OUT, ERASED_BYTE);
		chk({7'h00, PAR_DATA_OE_N}, 8'h00);
		PAR_RD_STB <= 1'b0;
		i_fepc_writer_model.leave_par();
		rd_chk(OFS_ADDR_LO, 8'h02);
		rd_chk(OFS_ADDR_HI, 8'h10);
		chk(BUF_CHECKSUM, 8'h6B);
	endtask : t_par
	// Main sequence: reset, hidden bank, debug entry, then each scenario
	initial begin
		{SRST, SFR_WR, SFR_RD, DEBUG_ACTIVE, PROG_ENTER, PAR_RD_STB} = 6'b100000;
		{SFR_ADDR, SFR_WDATA, flip} = 24'h0;
		{fails, tests_run} = 64'h0;
		repeat (20) @(posedge CLK_SYS);
		SRST <= 1'b0;
		repeat (3) @(posedge CLK_SYS);
		t_gate();
		DEBUG_ACTIVE <= 1'b1;
		PROG_ENTER <= 1'b1;
		@(posedge CLK_SYS);
		PROG_ENTER <= 1'b0;
		@(posedge CLK_SYS);
		t_regs();
		t_bulk();
		t_program();
		t_verify();
		t_refuse();
		t_crst();
		t_exit();
		t_par();
		final_report();
	end
endmodule : tb_top
`default_nettype wire
